// ===== src/serial_interrupt_fifo_control.sv
//
// Behaviour
// (RULE1) Rank interrupts: line status, receive data/timeout, transmit empty, modem status.
// (RULE2) Identity read freezes highest pending interrupt until it is serviced.
// (RULE3) Identity bit 0 reads 0 while an enabled interrupt pends, else 1.
// (RULE4) Identity codes 0110, 0100, 0010, 0000, and 0001 for nothing pending.
// (RULE5) Character timeout identifies as 1100 at receive data priority.
// (RULE6) Identity bits 5:4 read 0; bits 7:6 read 1 in FIFO mode.
// (RULE7) Timeout when receive FIFO nonempty and idle for four character times.
// (RULE8) Clear by line status read, receive read, identity read/holding write, modem read.
// (RULE9) Interrupt output driven only while handshake bit 3 is set.
// (RULE10) Enable bits: 0 rx data, 1 tx empty, 2 line, 3 modem; 7:4 zero.
// (RULE11) All enables clear inhibit identity and interrupt; status flags still update.
// (RULE12) Interrupt output is active high.
// (RULE13) Scratch register reads back as written and affects nothing else.
// (RULE14) FIFO control is written where identity is read.
// (RULE15) Control bit 0 enables both FIFOs without flushing them.
// (RULE16) Clearing control bit 0 discards receive error FIFO contents.
// (RULE17) Control bits 7:1 ignored unless bit 0 is 1 in the same write.
// (RULE18) Host should flush both FIFOs right after entering FIFO mode.
// (RULE19) Control bit 1 flushes receive FIFO and counters, then self-clears.
// (RULE20) Control bit 2 flushes transmit FIFO and counters, then self-clears.
// (RULE21) Control bit 3 with FIFOs on selects ready pin mode 1.
// (RULE22) Control bits 7:6 pick trigger level 1, 4, 8 or 14 bytes.
// (RULE23) Handshake bit 0 drives terminal-ready output inverted.
// (RULE24) Receive data interrupt follows fill at or above trigger level.
// (RULE25) Interrupt pin undriven while handshake bit 3 is 0.
//
// The register addresses and the strobed register port were chosen for this implementation.
`include "serial_irq_defines.svh"
`default_nettype none

module serial_interrupt_fifo_control #(
   parameter int FILL_W = 5
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Register port
   input  wire logic [2:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [7:0]        rdata,
   // Data path of the rest of the channel
   input  wire logic [7:0]        rx_data_in,
   input  wire logic [7:0]        line_status_in,
   input  wire logic [7:0]        modem_status_in,
   input  wire logic [7:0]        line_ctrl_in,
   input  wire logic              line_err_evt,
   input  wire logic              modem_delta_evt,
   input  wire logic              rx_push_evt,
   input  wire logic              thr_empty_evt,
   input  wire logic              char_time_tick,
   input  wire logic [FILL_W-1:0] rx_fill,
   // Strobes and control levels to the rest of the channel
   output logic                   rx_pop,
   output logic                   tx_push,
   output logic                   line_ctrl_wr,
   output logic                   line_status_rd,
   output logic                   modem_status_rd,
   output logic                   rx_fifo_flush,
   output logic                   tx_fifo_flush,
   output logic                   rx_err_discard,
   output logic                   fifo_enable,
   output logic                   ready_pin_mode,
   output logic      [4:0]        handshake_ctrl,
   // Pins
   output logic                   term_ready_n,
   output logic                   irq_out,
   output logic                   irq_oe
);

   // Fill count must hold the top trigger level and a full FIFO
   if (FILL_W < 5 || FILL_W > 8) begin
      $error("FILL_W must be 5 to 8");
   end

   // Register state
   logic [3:0]                 int_enable_ff;
   logic [7:0]                 scratch_ff;
   logic [`HCTL_WIDTH-1:0]     handshake_ff;
   logic                       fifo_en_ff;
   logic                       pin_mode_ff;
   logic [1:0]                 trig_ff;
   logic                       rx_flush_ff;
   logic                       tx_flush_ff;
   logic                       discard_ff;
   logic [7:0]                 rdata_ff;

   // Interrupt state
   logic                       line_flag_ff;
   logic                       modem_flag_ff;
   logic                       rxdata_flag_ff;
   logic                       thre_flag_ff;
   logic                       timeout_flag_ff;
   logic [2:0]                 idle_chars_ff;
   logic                       frozen_ff;
   serial_irq_pkg::irq_src_t   frozen_src_ff;

   // Access decode
   logic                       rd_data;
   logic                       wr_data;
   logic                       rd_ident;
   logic                       wr_fctl;
   logic                       rd_line;
   logic                       rd_modem;

   // Data port pops on read and pushes on write
   assign rd_data  = rd && addr == `OFS_DATA;
   assign wr_data  = wr && addr == `OFS_DATA;
   assign rd_ident = rd && addr == `OFS_INT_IDENT;
   assign wr_fctl  = wr && addr == `OFS_INT_IDENT;  // see (RULE14)
   assign rd_line  = rd && addr == `OFS_LINE_STATUS;
   assign rd_modem = rd && addr == `OFS_MODEM_STAT;

   // Pending sources after enable gating
   logic [FILL_W-1:0]          trig_level;
   logic                       rx_level_hit;
   logic                       p_line;
   logic                       p_rx;
   logic                       p_tmo;
   logic                       p_thre;
   logic                       p_modem;
   serial_irq_pkg::irq_src_t   top_src;
   serial_irq_pkg::irq_src_t   shown_src;
   logic                       frozen_live;
   logic [3:0]                 ident_code;

   // Trigger level in bytes
   always_comb begin
      case (trig_ff)  // see (RULE22)
         2'h0:    trig_level = FILL_W'(`TRIG_LVL_0);
         2'h1:    trig_level = FILL_W'(`TRIG_LVL_1);
         2'h2:    trig_level = FILL_W'(`TRIG_LVL_2);
         default: trig_level = FILL_W'(`TRIG_LVL_3);
      endcase
   end

   assign rx_level_hit = rx_fill >= trig_level;  // see (RULE24)

   // see (RULE10) (RULE11)
   assign p_line  = line_flag_ff && int_enable_ff[`IEN_LINE];
   // Character mode uses the sticky flag, FIFO mode the fill level
   assign p_rx    = int_enable_ff[`IEN_RXDATA] && (fifo_en_ff ? rx_level_hit : rxdata_flag_ff);
   assign p_tmo   = int_enable_ff[`IEN_RXDATA] && timeout_flag_ff;
   assign p_thre  = thre_flag_ff && int_enable_ff[`IEN_THRE];
   assign p_modem = modem_flag_ff && int_enable_ff[`IEN_MODEM];

   always_comb begin
      // Fixed ranking, highest first; see (RULE1)
      if (p_line) begin
         top_src = serial_irq_pkg::src_line;
      end else if (p_rx) begin
         top_src = serial_irq_pkg::src_rxdata;
      end else if (p_tmo) begin
         top_src = serial_irq_pkg::src_timeout;  // see (RULE5)
      end else if (p_thre) begin
         top_src = serial_irq_pkg::src_thre;
      end else if (p_modem) begin
         top_src = serial_irq_pkg::src_modem;
      end else begin
         top_src = serial_irq_pkg::src_none;
      end
   end

   // Whether the held source still pends
   always_comb begin
      case (frozen_src_ff)
         serial_irq_pkg::src_line:    frozen_live = p_line;
         serial_irq_pkg::src_rxdata:  frozen_live = p_rx;
         serial_irq_pkg::src_timeout: frozen_live = p_tmo;
         serial_irq_pkg::src_thre:    frozen_live = p_thre;
         serial_irq_pkg::src_modem:   frozen_live = p_modem;
         default:                     frozen_live = 1'b0;
      endcase
   end

   // Held source stays shown until serviced; see (RULE2)
   assign shown_src = (frozen_ff && frozen_live) ? frozen_src_ff : top_src;

   always_comb begin
      case (shown_src)  // see (RULE4) (RULE5)
         serial_irq_pkg::src_line:    ident_code = `ID_LINE;
         serial_irq_pkg::src_rxdata:  ident_code = `ID_RXDATA;
         serial_irq_pkg::src_timeout: ident_code = `ID_TIMEOUT;
         serial_irq_pkg::src_thre:    ident_code = `ID_THRE;
         serial_irq_pkg::src_modem:   ident_code = `ID_MODEM;
         default:                     ident_code = `ID_NONE;  // see (RULE3)
      endcase
   end

   // Freeze on identity read
   // Released once the held source no longer pends
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         frozen_ff     <= 1'b0;
         frozen_src_ff <= serial_irq_pkg::src_none;
      end else if (rd_ident && shown_src != serial_irq_pkg::src_none) begin
         frozen_ff     <= 1'b1;  // see (RULE2)
         frozen_src_ff <= shown_src;
      end else if (frozen_ff && !frozen_live) begin
         frozen_ff     <= 1'b0;
         frozen_src_ff <= serial_irq_pkg::src_none;
      end
   end

   // Sticky source flags: a set in the clearing cycle wins; see (RULE8)
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         line_flag_ff <= 1'b0;
      end else if (line_err_evt) begin
         line_flag_ff <= 1'b1;
      end else if (rd_line) begin
         line_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         modem_flag_ff <= 1'b0;
      end else if (modem_delta_evt) begin
         modem_flag_ff <= 1'b1;
      end else if (rd_modem) begin
         modem_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rxdata_flag_ff <= 1'b0;
      end else if (rx_push_evt) begin
         rxdata_flag_ff <= 1'b1;
      end else if (rd_data) begin
         rxdata_flag_ff <= 1'b0;  // see (RULE8)
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         thre_flag_ff <= 1'b0;
      end else if (thr_empty_evt) begin
         thre_flag_ff <= 1'b1;
      // Identity read clears it only while holding empty is shown
      end else if (wr_data || (rd_ident && shown_src == serial_irq_pkg::src_thre)) begin
         thre_flag_ff <= 1'b0;  // see (RULE8)
      end
   end

   // Receive silence counter in character times
   // Saturates at the limit so a long silence cannot wrap
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idle_chars_ff <= 3'h0;
      end else if (!fifo_en_ff || rx_push_evt || rd_data || rx_flush_ff || rx_fill == '0) begin
         idle_chars_ff <= 3'h0;  // see (RULE7)
      end else if (char_time_tick && idle_chars_ff != `TIMEOUT_CHARS) begin
         idle_chars_ff <= idle_chars_ff + 3'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timeout_flag_ff <= 1'b0;
      end else if (rd_data || !fifo_en_ff || rx_flush_ff) begin
         // Read restarts the timer, so clearing goes first here
         timeout_flag_ff <= 1'b0;  // see (RULE8)
      end else if (rx_fill != '0 && idle_chars_ff == `TIMEOUT_CHARS) begin
         timeout_flag_ff <= 1'b1;  // see (RULE7)
      end
   end

   // Interrupt enable
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_enable_ff <= `RST_INT_ENABLE;
      end else if (wr && addr == `OFS_INT_ENABLE) begin
         int_enable_ff <= wdata[3:0];  // see (RULE10)
      end
   end

   // Scratch
   // No side effect on any other function
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scratch_ff <= `RST_SCRATCH;
      end else if (wr && addr == `OFS_SCRATCH) begin
         scratch_ff <= wdata;  // see (RULE13)
      end
   end

   // Handshake control
   // Bits 7:5 are not stored and read as zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         handshake_ff <= `RST_HANDSHAKE;
      end else if (wr && addr == `OFS_HANDSHAKE) begin
         handshake_ff <= wdata[`HCTL_WIDTH-1:0];
      end
   end

   // FIFO control; bits above 0 only taken with bit 0 set
   // Pin mode and trigger are kept while the FIFOs are off
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fifo_en_ff  <= 1'b0;
         pin_mode_ff <= 1'b0;
         trig_ff     <= `RST_TRIG;
      end else if (wr_fctl) begin
         fifo_en_ff <= wdata[`FCTL_ENABLE];  // see (RULE15)
         if (wdata[`FCTL_ENABLE]) begin
            pin_mode_ff <= wdata[`FCTL_PIN_MODE];  // see (RULE17)
            trig_ff     <= wdata[`FCTL_TRIG_HI:`FCTL_TRIG_LO];
         end
      end
   end

   // One-cycle flush pulses; nothing to clear afterwards
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_flush_ff <= 1'b0;
         tx_flush_ff <= 1'b0;
         discard_ff  <= 1'b0;
      end else begin
         rx_flush_ff <= wr_fctl && wdata[`FCTL_ENABLE] && wdata[`FCTL_RX_FLUSH];  // see (RULE19)
         tx_flush_ff <= wr_fctl && wdata[`FCTL_ENABLE] && wdata[`FCTL_TX_FLUSH];  // see (RULE20)
         discard_ff  <= wr_fctl && !wdata[`FCTL_ENABLE];  // see (RULE16)
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (rd) begin
         if (addr == `OFS_DATA) begin
            rdata_ff <= rx_data_in;
         end else if (addr == `OFS_INT_ENABLE) begin
            rdata_ff <= {4'h0, int_enable_ff};
         end else if (addr == `OFS_INT_IDENT) begin
            rdata_ff <= {{2{fifo_en_ff}}, 2'h0, ident_code};  // see (RULE6)
         end else if (addr == `OFS_LINE_CTRL) begin
            rdata_ff <= line_ctrl_in;
         end else if (addr == `OFS_HANDSHAKE) begin
            rdata_ff <= {3'h0, handshake_ff};
         end else if (addr == `OFS_LINE_STATUS) begin
            rdata_ff <= line_status_in;
         end else if (addr == `OFS_MODEM_STAT) begin
            rdata_ff <= modem_status_in;
         end else begin
            rdata_ff <= scratch_ff;
         end
      end
   end

   assign rdata           = rdata_ff;
   assign rx_pop          = rd_data;
   assign tx_push         = wr_data;
   assign line_ctrl_wr    = wr && addr == `OFS_LINE_CTRL;
   assign line_status_rd  = rd_line;
   assign modem_status_rd = rd_modem;
   assign rx_fifo_flush   = rx_flush_ff;
   assign tx_fifo_flush   = tx_flush_ff;
   assign rx_err_discard  = discard_ff;
   assign fifo_enable     = fifo_en_ff;
   assign ready_pin_mode  = fifo_en_ff && pin_mode_ff;  // see (RULE21)
   assign handshake_ctrl  = handshake_ff;
   assign term_ready_n    = !handshake_ff[`HCTL_TERM_READY];  // see (RULE23)
   // Live ranking: a held identity never hides a newer request
   // Active-high request, enabled by handshake bit 3; see (RULE9) (RULE12) (RULE25)
   assign irq_out         = handshake_ff[`HCTL_INT_ENABLE] && top_src != serial_irq_pkg::src_none;
   assign irq_oe          = handshake_ff[`HCTL_INT_ENABLE];

endmodule

`default_nettype wire

// ===== include/serial_irq_defines.svh
`ifndef SERIAL_IRQ_DEFINES_SVH
`define SERIAL_IRQ_DEFINES_SVH

// Register offsets
`define OFS_DATA        3'h0
`define OFS_INT_ENABLE  3'h1
`define OFS_INT_IDENT   3'h2
`define OFS_LINE_CTRL   3'h3
`define OFS_HANDSHAKE   3'h4
`define OFS_LINE_STATUS 3'h5
`define OFS_MODEM_STAT  3'h6
`define OFS_SCRATCH     3'h7

// Interrupt enable fields
`define IEN_RXDATA      0
`define IEN_THRE        1
`define IEN_LINE        2
`define IEN_MODEM       3

// FIFO control fields
`define FCTL_ENABLE     0
`define FCTL_RX_FLUSH   1
`define FCTL_TX_FLUSH   2
`define FCTL_PIN_MODE   3
`define FCTL_TRIG_LO    6
`define FCTL_TRIG_HI    7

// Handshake control fields
`define HCTL_TERM_READY 0
`define HCTL_INT_ENABLE 3
`define HCTL_WIDTH      5

// Identity codes, bits 3..0
`define ID_NONE         4'h1
`define ID_LINE         4'h6
`define ID_RXDATA       4'h4
`define ID_TIMEOUT      4'hc
`define ID_THRE         4'h2
`define ID_MODEM        4'h0

// Receive trigger levels in bytes
`define TRIG_LVL_0      5'h01
`define TRIG_LVL_1      5'h04
`define TRIG_LVL_2      5'h08
`define TRIG_LVL_3      5'h0e

// Character times of receive silence before timeout
`define TIMEOUT_CHARS   3'h4

// Reset values
`define RST_INT_ENABLE  4'h0
`define RST_HANDSHAKE   5'h00
`define RST_SCRATCH     8'h00
`define RST_TRIG        2'h0

`endif

// ===== include/serial_irq_pkg.sv
`default_nettype none
package serial_irq_pkg;
   typedef enum logic [2:0] {
      src_none,
      src_line,
      src_rxdata,
      src_timeout,
      src_thre,
      src_modem
   } irq_src_t;
endpackage
`default_nettype wire

// ===== bench/serial_irq_checker_sva.sv
`default_nettype none
module serial_irq_checker #(
   parameter int FILL_W = 5
) (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       rx_pop,
   input wire logic       tx_push,
   input wire logic       line_ctrl_wr,
   input wire logic       line_status_rd,
   input wire logic       modem_status_rd,
   input wire logic       rx_fifo_flush,
   input wire logic       tx_fifo_flush,
   input wire logic       rx_err_discard,
   input wire logic       fifo_enable,
   input wire logic       ready_pin_mode,
   input wire logic [4:0] handshake_ctrl,
   input wire logic       term_ready_n,
   input wire logic       irq_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);
   wire logic fc_wr = wr && addr == 3'h2;
   property p_fc_on; fc_wr && wdata[0] |=> fifo_enable; endproperty
   a_fc_on: assert property (p_fc_on) else $error("fifo mode not entered");
   property p_rx_flush; fc_wr && wdata[1:0] == 2'h3 |=> rx_fifo_flush ##1 !rx_fifo_flush; endproperty
   a_rx_flush: assert property (p_rx_flush) else $error("rx flush pulse wrong");
   property p_tx_flush; fc_wr && wdata[0] && wdata[2] |=> tx_fifo_flush ##1 !tx_fifo_flush; endproperty
   a_tx_flush: assert property (p_tx_flush) else $error("tx flush pulse wrong");
   property p_fc_ignore; fc_wr && !wdata[0] |=> !rx_fifo_flush && !tx_fifo_flush && !ready_pin_mode; endproperty
   a_fc_ignore: assert property (p_fc_ignore) else $error("control bits taken without enable");
   property p_discard; fc_wr && !wdata[0] && fifo_enable |=> rx_err_discard; endproperty
   a_discard: assert property (p_discard) else $error("error fifo not discarded");
   property p_id_bits; rd && addr == 3'h2 |=> rdata[5:4] == 2'h0 && rdata[7:6] == {2{$past(fifo_enable)}}; endproperty
   a_id_bits: assert property (p_id_bits) else $error("identity upper bits wrong");
   property p_ien_hi; rd && addr == 3'h1 |=> rdata[7:4] == 4'h0; endproperty
   a_ien_hi: assert property (p_ien_hi) else $error("enable upper bits not zero");
   property p_pin_mode; ready_pin_mode |-> fifo_enable; endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("pin mode without fifo");
   property p_dtr; term_ready_n == !handshake_ctrl[0]; endproperty
   a_dtr: assert property (p_dtr) else $error("terminal ready not inverted");
   property p_oe; irq_oe == handshake_ctrl[3]; endproperty
   a_oe: assert property (p_oe) else $error("interrupt pin enable wrong");
   property p_pop; rx_pop == (rd && addr == 3'h0); endproperty
   a_pop: assert property (p_pop) else $error("receive pop strobe wrong");
   property p_rd_strb; line_status_rd == (rd && addr == 3'h5) && modem_status_rd == (rd && addr == 3'h6); endproperty
   a_rd_strb: assert property (p_rd_strb) else $error("status read strobe wrong");
   property p_wr_strb; tx_push == (wr && addr == 3'h0) && line_ctrl_wr == (wr && addr == 3'h3); endproperty
   a_wr_strb: assert property (p_wr_strb) else $error("write strobe wrong");
endmodule
bind serial_interrupt_fifo_control serial_irq_checker #(.FILL_W(FILL_W)) serial_irq_checker_i (
   .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_pop, .tx_push, .line_ctrl_wr, .line_status_rd,
   .modem_status_rd, .rx_fifo_flush, .tx_fifo_flush,
   .rx_err_discard, .fifo_enable, .ready_pin_mode, .handshake_ctrl, .term_ready_n, .irq_oe
);
`default_nettype wire

// ===== bench/rx_fill_model.sv
`default_nettype none
module rx_fill_model #(
   parameter int FILL_W = 5
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              push,
   input  wire logic              pop,
   input  wire logic              flush,
   output logic      [FILL_W-1:0] fill
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [FILL_W-1:0] fill_ff;
   assign fill = fill_ff;
   // Receive FIFO occupancy as the rest of the channel counts it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fill_ff <= '0;
      end else if (flush) begin
         fill_ff <= '0;
      end else if (push && !pop) begin
         fill_ff <= fill_ff + 1'b1;
      end else if (pop && !push && fill_ff != '0) begin
         fill_ff <= fill_ff - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== bench/serial_interrupt_fifo_control_test.sv
`default_nettype none
module serial_interrupt_fifo_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int FILL_W = 5;
   logic              mclk, rst, wr, rd, rx_pop, tx_push, line_ctrl_wr, line_status_rd, modem_status_rd;
   logic              line_err_evt, modem_delta_evt, rx_push_evt, thr_empty_evt, char_time_tick;
   logic              rx_fifo_flush, tx_fifo_flush, rx_err_discard, fifo_enable, ready_pin_mode;
   logic              term_ready_n, irq_out, irq_oe;
   logic [2:0]        addr;
   logic [7:0]        wdata, rdata, rx_data_in, line_status_in, modem_status_in, line_ctrl_in;
   logic [4:0]        handshake_ctrl, ev;
   logic [FILL_W-1:0] rx_fill;
   logic [31:0]       ext;
   int                fails = 0;
   int                checked = 0;
   assign {line_err_evt, modem_delta_evt, rx_push_evt, thr_empty_evt, char_time_tick} = ev;
   assign {rx_data_in, line_status_in, modem_status_in, line_ctrl_in} = ext;
   serial_interrupt_fifo_control #(.FILL_W(FILL_W)) serial_interrupt_fifo_control_i (
      .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_data_in, .line_status_in, .modem_status_in,
      .line_ctrl_in, .line_err_evt, .modem_delta_evt, .rx_push_evt, .thr_empty_evt, .char_time_tick,
      .rx_fill, .rx_pop, .tx_push, .line_ctrl_wr, .line_status_rd, .modem_status_rd, .rx_fifo_flush,
      .tx_fifo_flush, .rx_err_discard, .fifo_enable, .ready_pin_mode, .handshake_ctrl, .term_ready_n,
      .irq_out, .irq_oe
   );
   rx_fill_model #(.FILL_W(FILL_W)) rx_fill_model_i (
      .mclk, .rst, .push(rx_push_evt), .pop(rx_pop), .flush(rx_fifo_flush), .fill(rx_fill)
   );
   function automatic logic [7:0] ident(input logic fe, input logic [3:0] code);
      return {fe, fe, 2'h0, code};
   endfunction
   function automatic int trig(input int sel);
      int lv[4] = '{1, 4, 8, 14};
      return lv[sel];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string m);
      logic [7:0] d;
      rreg(a, d);
      chk(d, exp, m);
   endtask
   // Events are bit-ordered line, modem, push, holding empty, tick
   task automatic pulse(input logic [4:0] v, input int n);
      repeat (n) begin
         @(posedge mclk);
         ev <= v;
         @(posedge mclk);
         ev <= 5'h00;
      end
      @(posedge mclk);
      #1;
   endtask
   task automatic finish_test();
      if (fails == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      finish_test();
   end
   initial begin
      logic [7:0] d;
      rst = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ev = 5'h00;
      void'($urandom(32'h87122f47));
      ext = $urandom;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rchk(3'h1, 8'h00, "enable after reset");
      rchk(3'h2, ident(1'b0, 4'h1), "identity idle");
      for (int i = 0; i < 6; i++) begin
         d = $urandom;
         wreg(3'h7, d);
         wreg(3'h1, d);
         wreg(3'h4, d);
         chk({7'h0, term_ready_n}, {7'h0, ~d[0]}, "terminal ready");
         chk({7'h0, irq_oe}, {7'h0, d[3]}, "pin enable");
         rchk(3'h7, d, "scratch");
         rchk(3'h1, {4'h0, d[3:0]}, "enable readback");
         rchk(3'h2, ident(1'b0, 4'h1), "identity untouched");
      end
      wreg(3'h1, 8'h00);
      wreg(3'h4, 8'h08);
      pulse(5'h10, 1);
      chk({7'h0, irq_out}, 8'h00, "irq while disabled");
      rchk(3'h2, ident(1'b0, 4'h1), "identity inhibited");
      wreg(3'h1, 8'h04);
      chk({7'h0, irq_out}, 8'h01, "kept line flag");
      rchk(3'h5, ext[23:16], "line status");
      chk({7'h0, irq_out}, 8'h00, "line cleared");
      wreg(3'h1, 8'h0f);
      pulse(5'h1a, 1);
      rchk(3'h2, ident(1'b0, 4'h6), "line first");
      rreg(3'h5, d);
      rchk(3'h2, ident(1'b0, 4'h2), "holding empty third");
      rchk(3'h2, ident(1'b0, 4'h0), "modem last");
      rchk(3'h6, ext[15:8], "modem status");
      rchk(3'h2, ident(1'b0, 4'h1), "all serviced");
      pulse(5'h02, 1);
      wreg(3'h0, 8'h55);
      rchk(3'h2, ident(1'b0, 4'h1), "holding write clears");
      wreg(3'h2, 8'h07);
      rchk(3'h2, ident(1'b1, 4'h1), "fifo mode shown");
      wreg(3'h2, 8'h08);
      wreg(3'h2, 8'h01);
      chk({7'h0, ready_pin_mode}, 8'h00, "ignored mode bit");
      wreg(3'h2, 8'h09);
      chk({7'h0, ready_pin_mode}, 8'h01, "pin mode one");
      wreg(3'h1, 8'h01);
      for (int t = 0; t < 4; t++) begin
         wreg(3'h2, {t[1:0], 6'h03});
         pulse(5'h04, trig(t) - 1);
         chk({7'h0, irq_out}, 8'h00, "below trigger");
         pulse(5'h04, 1);
         chk({7'h0, irq_out}, 8'h01, "at trigger");
         rchk(3'h2, ident(1'b1, 4'h4), "receive data");
         rreg(3'h0, d);
         chk({7'h0, irq_out}, 8'h00, "fell below");
      end
      wreg(3'h2, 8'hc3);
      pulse(5'h04, 1);
      pulse(5'h01, 3);
      rchk(3'h2, ident(1'b1, 4'h1), "three char times");
      pulse(5'h01, 1);
      rchk(3'h2, ident(1'b1, 4'hc), "timeout");
      rchk(3'h0, ext[31:24], "receive data byte");
      chk({7'h0, irq_out}, 8'h00, "timeout cleared");
      wreg(3'h2, 8'h00);
      rchk(3'h2, ident(1'b0, 4'h1), "fifo mode off");
      finish_test();
   end
endmodule
`default_nettype wire
